// ===== design/xfer_queue_pkg.sv
// Shared constants for the image block transfer queue
package xfer_queue_pkg;
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] COUNT_OFF = 8'h04;
  localparam logic [7:0] CMD_OFF = 8'h08;
  localparam logic [7:0] CAP_OFF = 8'h0C;
  localparam logic [7:0] OCC_OFF = 8'h10;
  localparam logic [7:0] DROP_OFF = 8'h14;
  localparam logic [7:0] STAT_OFF = 8'h18;
  // Control word fields
  localparam int METHOD_LSB = 0;
  localparam int RUN_STYLE_BIT = 2;
  localparam int CHAN_OPEN_BIT = 3;
  localparam int POLICY_LSB = 8;
  // Command word fields
  localparam int GO_BIT = 0;
  localparam int HALT_BIT = 1;
  // Status word fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_SEND_BIT = 1;
  // Encodings
  localparam logic [1:0] METHOD_BASIC = 2'h0;
  localparam logic [1:0] METHOD_AUTOMATIC = 2'h1;
  localparam logic [1:0] METHOD_USER = 2'h2;
  localparam logic STYLE_CONTINUOUS = 1'h0;
  localparam logic STYLE_MULTI = 1'h1;
  localparam logic [1:0] POLICY_OLDEST_FIRST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Reset values
  localparam logic [1:0] RST_METHOD = METHOD_BASIC;
  localparam logic RST_RUN_STYLE = STYLE_CONTINUOUS;
  localparam logic RST_CHAN_OPEN = 1'h1;
  localparam logic [31:0] RST_BLOCKS_TO_SEND = 32'h00000001;
  // Default sizes
  localparam int DEF_QUEUE_DEPTH = 4;
  localparam int DEF_MAX_WORDS = 64;
  localparam int DEF_PACKET_WORDS = 8;
  localparam int DEF_DATA_W = 32;
  localparam int DEF_OUT_FIFO_DEPTH = 4;
  // Transmitter states
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
endpackage

// ===== design/image_block_transfer_queue.sv
// Image block transfer queue with its output word FIFO and register slave
// Summary of operation
// R1: Basic/automatic method starts a block once one packet of words is stored.
// R2: User method sends blocks only as run style and go/halt commands direct.
// R3: In user method, continuous style streams back to back, gated by go and halt.
// R4: In user method, multi-block style sends exactly the programmed number of blocks, then stops.
// R5: The block count is used only in multi-block style.
// R6: A read-only register reports the queue capacity in blocks.
// R7: A read-only register reports blocks currently held in the queue.
// R8: A read-only counter reports blocks dropped before being sent.
// R9: Queue policy offers oldest-first only; the oldest block always goes next.
// R10: A write-only go command starts streaming, honoured only in user method.
// R11: Halt, honoured only in user method, lets the current block finish first.
// R12: Full queue plus new block replaces oldest unsent block and counts a drop.
// R13: Closing the stream channel empties the queue and cancels pending sends.
// R14: Occupancy rises on enqueue, falls when a block finishes, never above capacity.
// R15: After a multi-block run the sender idles while blocks keep queueing.
`timescale 1ns/1ps

module stage_fifo #(
  parameter int W = 33,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] data;
    logic [DEPTH-1:0] vld;
  } fifo_state_t;
  fifo_state_t s;
  fifo_state_t next_s;

  // Shift toward the head on pop, fill the first empty entry on push
  always_comb begin
    logic placed;
    placed = 1'b0;
    next_s = s;
    if (s.vld[0] && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_s.data[i] = s.data[i+1];
        next_s.vld[i] = s.vld[i+1];
      end
      next_s.vld[DEPTH-1] = 1'b0;
    end
    if (in_valid && !s.vld[DEPTH-1]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !next_s.vld[i]) begin
          next_s.data[i] = in_data;
          next_s.vld[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Head entry drives the outputs directly
  assign in_ready = ~s.vld[DEPTH-1];
  assign out_data = s.data[0];
  assign out_valid = s.vld[0];
endmodule

module image_block_transfer_queue
  import xfer_queue_pkg::*;
#(
  parameter int QUEUE_DEPTH = DEF_QUEUE_DEPTH,
  parameter int MAX_WORDS = DEF_MAX_WORDS,
  parameter int PACKET_WORDS = DEF_PACKET_WORDS,
  parameter int DATA_W = DEF_DATA_W,
  parameter int OUT_FIFO_DEPTH = DEF_OUT_FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [DATA_W-1:0] blk_data,
  input wire logic blk_valid,
  input wire logic blk_last,
  output logic [DATA_W-1:0] tx_data,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready
);
  localparam int SW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
  localparam int IW = $clog2(MAX_WORDS + 1);
  localparam int CW = $clog2(QUEUE_DEPTH + 1);

  typedef struct packed {
    logic [QUEUE_DEPTH*MAX_WORDS-1:0][DATA_W-1:0] mem;
    logic [QUEUE_DEPTH-1:0][IW-1:0] len;
    logic [QUEUE_DEPTH-1:0] done;
    logic [QUEUE_DEPTH-1:0] used;
    logic [QUEUE_DEPTH-1:0][SW-1:0] order;
    logic [CW-1:0] count;
    logic [SW-1:0] fill_slot;
    logic fill_on;
    logic fill_skip;
    tx_state_t tx_state;
    logic [IW-1:0] tx_idx;
    logic run;
    logic [31:0] remaining;
    logic [1:0] method;
    logic run_style;
    logic chan_open;
    logic [1:0] policy;
    logic [31:0] blocks_to_send;
    logic [31:0] dropped;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;
  logic fifo_in_valid;
  logic [DATA_W:0] fifo_in_data;
  logic fifo_in_ready;

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8+:8] = new_v[b*8+:8];
      end
    end
    return r;
  endfunction

  // Address decode shared by reads and writes
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFF) || (a == COUNT_OFF) || (a == CMD_OFF) || (a == CAP_OFF) ||
           (a == OCC_OFF) || (a == DROP_OFF) || (a == STAT_OFF);
  endfunction

  // Lowest slot not holding a block
  function automatic logic [SW-1:0] first_free(input logic [QUEUE_DEPTH-1:0] used);
    logic [SW-1:0] r;
    r = '0;
    for (int i = QUEUE_DEPTH - 1; i >= 0; i--) begin
      if (!used[i]) begin
        r = SW'(i);
      end
    end
    return r;
  endfunction

  // Whole next-state computation
  always_comb begin
    logic [31:0] ctrl_word;
    logic [31:0] wd;
    logic go;
    logic halt;
    logic allowed;
    logic head_ready;
    logic word_ok;
    logic is_last;
    logic [SW-1:0] head;
    logic [SW-1:0] wslot;
    logic [IW:0] idx1;
    logic [IW:0] hlen;
    int di;
    ctrl_word = '0;
    wd = '0;
    go = 1'b0;
    halt = 1'b0;
    allowed = 1'b0;
    head_ready = 1'b0;
    word_ok = 1'b0;
    is_last = 1'b0;
    head = s.order[0];
    wslot = s.fill_slot;
    idx1 = {1'b0, s.tx_idx} + (IW+1)'(1);
    hlen = {1'b0, s.len[head]};
    di = 0;
    next_s = s;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    ctrl_word[METHOD_LSB+:2] = s.method;
    ctrl_word[RUN_STYLE_BIT] = s.run_style;
    ctrl_word[CHAN_OPEN_BIT] = s.chan_open;
    ctrl_word[POLICY_LSB+:2] = s.policy;

    // Write address and data are taken in either order
    if (s.awready && awvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (s.wready && wvalid) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_DECERR;
      case (s.aw_addr)
        CTRL_OFF: begin
          wd = merge_bytes(ctrl_word, s.w_data, s.w_strb);
          if (wd[METHOD_LSB+:2] <= METHOD_USER) begin
            next_s.method = wd[METHOD_LSB+:2]; // R2
          end
          next_s.run_style = wd[RUN_STYLE_BIT];
          next_s.chan_open = wd[CHAN_OPEN_BIT];
          if (wd[POLICY_LSB+:2] == POLICY_OLDEST_FIRST) begin
            next_s.policy = POLICY_OLDEST_FIRST; // R9
          end
        end
        COUNT_OFF: begin
          next_s.blocks_to_send = merge_bytes(s.blocks_to_send, s.w_data, s.w_strb);
        end
        CMD_OFF: begin
          go = s.w_data[GO_BIT] && s.w_strb[0];
          halt = s.w_data[HALT_BIT] && s.w_strb[0];
        end
        default: begin
        end
      endcase
    end
    next_s.awready = !next_s.aw_held;
    next_s.wready = !next_s.w_held;

    // Read channel, one read under way at a time
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s.arready && arvalid) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      case (araddr)
        CTRL_OFF: next_s.rdata = ctrl_word;
        COUNT_OFF: next_s.rdata = s.blocks_to_send;
        CAP_OFF: next_s.rdata = 32'(QUEUE_DEPTH); // R6
        OCC_OFF: next_s.rdata = 32'(s.count); // R7
        DROP_OFF: next_s.rdata = s.dropped; // R8
        STAT_OFF: begin
          next_s.rdata = '0;
          next_s.rdata[STAT_RUN_BIT] = s.run;
          next_s.rdata[STAT_SEND_BIT] = (s.tx_state == TX_SEND);
        end
        default: next_s.rdata = '0;
      endcase
    end

    if (!s.chan_open) begin
      // Closed channel drops every queued block and pending send
      next_s.used = '0; // R13
      next_s.count = '0; // R13
      next_s.fill_on = 1'b0;
      next_s.fill_skip = 1'b0;
      next_s.tx_state = TX_IDLE; // R13
      next_s.run = 1'b0;
      next_s.remaining = '0;
    end else begin
      // Sending permission by control method and run style
      if (s.method != METHOD_USER) begin
        allowed = 1'b1; // R1
      end else begin
        allowed = s.run && ((s.run_style == STYLE_CONTINUOUS) || (s.remaining != 0)); // R2 R3 R5
      end
      head_ready = s.done[head] || (hlen >= (IW+1)'(PACKET_WORDS)); // R1

      // Transmitter, always on the oldest queued block
      case (s.tx_state)
        TX_IDLE: begin
          if ((s.count != 0) && head_ready && allowed) begin
            next_s.tx_state = TX_SEND; // R9
            next_s.tx_idx = '0;
            if ((s.method == METHOD_USER) && (s.run_style == STYLE_MULTI)) begin
              next_s.remaining = s.remaining - 32'h00000001; // R4
              if (s.remaining == 32'h00000001) begin
                next_s.run = 1'b0; // R4 R15
              end
            end
          end
        end
        TX_SEND: begin
          word_ok = (idx1 < hlen) || (s.done[head] && ({1'b0, s.tx_idx} < hlen));
          is_last = s.done[head] && (idx1 == hlen);
          fifo_in_valid = word_ok;
          fifo_in_data = {is_last, s.mem[int'(head) * MAX_WORDS + int'(s.tx_idx)]};
          if (word_ok && fifo_in_ready) begin
            next_s.tx_idx = idx1[IW-1:0];
            if (is_last) begin
              // Finished block leaves the queue
              next_s.tx_state = TX_IDLE;
              next_s.used[head] = 1'b0;
              next_s.count = s.count - CW'(1); // R14
              for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
                next_s.order[i] = s.order[i+1];
              end
            end
          end
        end
        default: next_s.tx_state = TX_IDLE;
      endcase

      // Host commands, user method only; halt waits for the block in flight
      if (go && (s.method == METHOD_USER)) begin
        next_s.run = 1'b1; // R10
        next_s.remaining = s.blocks_to_send; // R4 R5
      end
      if (halt && (s.method == METHOD_USER)) begin
        next_s.run = 1'b0; // R11
      end

      // Arrival of block words from the processing path
      if (blk_valid) begin
        if (!s.fill_on) begin
          next_s.fill_skip = 1'b0;
          if (next_s.count == CW'(QUEUE_DEPTH)) begin
            di = (next_s.tx_state == TX_SEND) ? 1 : 0;
            next_s.dropped = s.dropped + 32'h00000001; // R8 R12
            if (di >= QUEUE_DEPTH) begin
              next_s.fill_skip = 1'b1;
            end else begin
              // Oldest unsent block gives up its slot to the newcomer
              wslot = next_s.order[di]; // R12
              for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
                if (i >= di) begin
                  next_s.order[i] = next_s.order[i+1];
                end
              end
              next_s.order[QUEUE_DEPTH-1] = wslot;
            end
          end else begin
            wslot = first_free(next_s.used);
            next_s.used[wslot] = 1'b1;
            next_s.order[next_s.count[SW-1:0]] = wslot;
            next_s.count = next_s.count + CW'(1); // R14
          end
          next_s.fill_slot = wslot;
          next_s.len[wslot] = '0;
          next_s.done[wslot] = 1'b0;
        end
        if (!next_s.fill_skip) begin
          // Words past the slot size are discarded
          if (next_s.len[wslot] < IW'(MAX_WORDS)) begin
            next_s.mem[int'(wslot) * MAX_WORDS + int'(next_s.len[wslot])] = blk_data;
            next_s.len[wslot] = next_s.len[wslot] + IW'(1);
          end
          next_s.done[wslot] = blk_last;
        end
        next_s.fill_on = !blk_last;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.method <= RST_METHOD;
      s.run_style <= RST_RUN_STYLE;
      s.chan_open <= RST_CHAN_OPEN;
      s.policy <= POLICY_OLDEST_FIRST;
      s.blocks_to_send <= RST_BLOCKS_TO_SEND;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.tx_state <= TX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Output word buffer toward the link
  stage_fifo #(
    .W(DATA_W + 1),
    .DEPTH(OUT_FIFO_DEPTH)
  ) u_out_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data({tx_last, tx_data}),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // Bus outputs straight from the state register
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
endmodule

// ===== dv/xfer_queue_monitor.sv
// Port-level checker for the transfer queue
`timescale 1ns/1ps
module xfer_queue_monitor
  import xfer_queue_pkg::*;
#(
  parameter int QUEUE_DEPTH = DEF_QUEUE_DEPTH,
  parameter int DATA_W = DEF_DATA_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read answers
  property p_cap;
    arvalid && arready && araddr == CAP_OFF |=> rvalid && rdata == QUEUE_DEPTH;
  endproperty
  a_cap: assert property (p_cap) else $error("capacity read wrong");
  property p_occ;
    arvalid && arready && araddr == OCC_OFF |=> rvalid && rdata <= QUEUE_DEPTH;
  endproperty
  a_occ: assert property (p_occ) else $error("occupancy above capacity");
  property p_cmd;
    arvalid && arready && araddr == CMD_OFF |=> rdata == 32'h0 && rresp == RESP_OKAY;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command word readable");
  property p_unmap;
    arvalid && arready && araddr > STAT_OFF |=> rresp == RESP_DECERR && rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_r_done;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read answer stuck");
  // Write answers
  property p_wr;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_b_done;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer stuck");
  // Stream word held while the host stalls
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("stream word changed");
  // Main scenarios
  c_drop: cover property (arvalid && arready && araddr == DROP_OFF ##1 rdata == 32'h2);
  c_stall: cover property ((tx_valid && !tx_ready) [*3]);
  c_last: cover property (tx_valid && tx_ready && tx_last);
endmodule

// ===== dv/host_sink.sv
// Host stream receiver model with optional stalling
`timescale 1ns/1ps
module host_sink (
  input wire logic aclk,
  input wire logic [31:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic stall
);
  logic [32:0] got[$];
  logic [1:0] ph = 2'h0;
  // Collects each accepted word with its last mark
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back({tx_last, tx_data});
    end
    ph <= ph + 2'h1;
  end
  // Slow host takes one word in four cycles
  assign tx_ready = !stall || ph == 2'h3;
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the image block transfer queue
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top
  import xfer_queue_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000, blk_data = 32'h00000000;
  logic blk_valid = 1'b0, blk_last = 1'b0, stall = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_last, tx_valid, tx_ready;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, tx_data, d;
  int miscompares = 0, n_tests = 0;
  image_block_transfer_queue #(.QUEUE_DEPTH(4)) image_block_transfer_queue_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .blk_data, .blk_valid, .blk_last, .tx_data, .tx_last,
    .tx_valid, .tx_ready
  );
  host_sink host_sink_i (.aclk, .tx_data, .tx_last, .tx_valid, .tx_ready, .stall);
  // Clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Register read, held until the answer
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Register write, address and data together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  // One block of n words counting up from b
  task automatic blk(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      blk_data <= b + i;
      blk_valid <= 1'b1;
      blk_last <= (i == n - 1);
      @(posedge aclk);
    end
    blk_valid <= 1'b0;
    blk_last <= 1'b0;
    @(posedge aclk);
  endtask
  // Expect one block of n words at the host
  task automatic take(input logic [31:0] b, input int n);
    logic [32:0] w;
    for (int i = 0; i < n; i++) begin
      while (host_sink_i.got.size() == 0) @(posedge aclk);
      w = host_sink_i.got.pop_front();
      `CHK(w, {i == n - 1, b + i})
    end
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    report_and_stop();
  end
  // Test sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(CTRL_OFF, 32'h00000008);
    chk(COUNT_OFF, 32'h00000001);
    chk(CAP_OFF, 32'h00000004);
    chk(OCC_OFF, 32'h00000000);
    chk(DROP_OFF, 32'h00000000);
    chk(CMD_OFF, 32'h00000000);
    rd(8'h1C);
    `CHK(rsp, RESP_DECERR)
    wr(CAP_OFF, 32'h00000009);
    `CHK(rsp, RESP_OKAY)
    chk(CAP_OFF, 32'h00000004);
    wr(8'h1C, 32'h00000001);
    `CHK(rsp, RESP_DECERR)
    wr(CTRL_OFF, 32'h00000108);
    chk(CTRL_OFF, 32'h00000008);
    $display("test registers done");
    stall <= 1'b1;
    wr(CMD_OFF, 32'h00000002);
    for (int m = 0; m < 2; m++) begin
      wr(CTRL_OFF, 32'h00000008 | m);
      blk(32'h00000100, 3);
      blk(32'h00000200, 2);
      take(32'h00000100, 3);
      take(32'h00000200, 2);
    end
    stall <= 1'b0;
    chk(OCC_OFF, 32'h00000000);
    $display("test streaming done");
    wr(CTRL_OFF, 32'h0000000A);
    for (int k = 1; k <= 6; k++) begin
      blk(32'h00000010 * k, 1);
    end
    chk(OCC_OFF, 32'h00000004);
    chk(DROP_OFF, 32'h00000002);
    wr(CMD_OFF, 32'h00000001);
    for (int k = 3; k <= 6; k++) begin
      take(32'h00000010 * k, 1);
    end
    $display("test overflow done");
    wr(CMD_OFF, 32'h00000002);
    wr(COUNT_OFF, 32'h00000002);
    wr(CTRL_OFF, 32'h0000000E);
    for (int k = 7; k <= 9; k++) begin
      blk(32'h00000010 * k, 1);
    end
    wr(CMD_OFF, 32'h00000001);
    take(32'h00000070, 1);
    take(32'h00000080, 1);
    repeat (40) @(posedge aclk);
    `CHK(host_sink_i.got.size(), 0)
    chk(STAT_OFF, 32'h00000000);
    chk(OCC_OFF, 32'h00000001);
    wr(CTRL_OFF, 32'h0000000A);
    blk(32'h000000A0, 1);
    blk(32'h000000B0, 1);
    wr(CMD_OFF, 32'h00000001);
    for (int k = 9; k <= 11; k++) begin
      take(32'h00000010 * k, 1);
    end
    chk(STAT_OFF, 32'h00000001);
    $display("test multi block done");
    fork
      blk(32'h00000500, 12);
      begin
        while (!tx_valid) @(posedge aclk);
        wr(CMD_OFF, 32'h00000002);
      end
    join
    take(32'h00000500, 12);
    blk(32'h00000600, 1);
    chk(OCC_OFF, 32'h00000001);
    wr(CTRL_OFF, 32'h00000002);
    chk(OCC_OFF, 32'h00000000);
    wr(CTRL_OFF, 32'h0000000A);
    wr(CMD_OFF, 32'h00000001);
    repeat (40) @(posedge aclk);
    `CHK(host_sink_i.got.size(), 0)
    $display("test halt and close done");
    report_and_stop();
  end
endmodule
bind image_block_transfer_queue xfer_queue_monitor #(
  .QUEUE_DEPTH(QUEUE_DEPTH), .DATA_W(DATA_W)
) xfer_queue_monitor_i (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tx_data, .tx_last,
  .tx_valid, .tx_ready
);
